// File: rtl/sar_ctl_defines.svh
// Purpose: timing counts and widths for the converter control
// Assumes: 250 MHz clock_in, 4 ns period
// Notes: definitions only
`ifndef SAR_CTL_DEFINES_SVH
`define SAR_CTL_DEFINES_SVH
`define RESULT_WIDTH 12
`define CLK_PERIOD_NS 4
// conversion time, longest figure, in ns
`define CONV_TIME_NS 1250
`define CONV_CYCLES (`CONV_TIME_NS / `CLK_PERIOD_NS)
// cycles spent deciding one bit
`define BIT_CYCLES (`CONV_CYCLES / `RESULT_WIDTH)
`define FIFO_DEPTH 8
`define SAR_CLEAR 12'h000
`endif

// File: rtl/sar_ctl_pkg.sv
// Purpose: shared types of the converter control
// Assumes: header sar_ctl_defines.svh
// Notes: types only
`include "sar_ctl_defines.svh"
package sar_ctl_pkg;
  typedef enum logic [1:0] {
    pwr_active_type_val,
    pwr_nap,
    pwr_sleep
  } power_mode_type;
  typedef struct packed {
    logic chip_select_n;
    logic convert_start_n;
    logic read_n;
    logic power_down_n;
    logic shutdown_depth_select;
  } host_pins_type;
endpackage

// File: rtl/result_fifo.sv
// Purpose: small word buffer for conversion results
// Assumes: one clock, synchronous active-high reset
// Notes: valid/ready both sides, honest full and empty
`timescale 1ns/1ns
module result_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // fill side
  input wire logic [WIDTH-1:0] fill_data_in,
  input wire logic fill_valid_in,
  output logic fill_ready_out,
  // drain side
  output logic [WIDTH-1:0] drain_data_out,
  output logic drain_valid_out,
  input wire logic drain_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] count_reg, count_next;
  logic push, pop;
  logic [WIDTH-1:0] head_reg, head_next;
  logic valid_reg, valid_next;
  // ==========================================
  // pointer and count update
  always_comb begin
    push = fill_valid_in && (count_reg != (AW+1)'(DEPTH));
    pop = drain_ready_in && (count_reg != '0);
    wr_next = push ? AW'(wr_reg + 1'b1) : wr_reg;
    rd_next = pop ? AW'(rd_reg + 1'b1) : rd_reg;
    count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
    valid_next = (count_next != '0);
    // a word written into the head slot is passed straight through
    head_next = (push && wr_reg == rd_next) ? fill_data_in : mem_reg[rd_next];
  end
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      wr_reg <= '0;
      rd_reg <= '0;
      count_reg <= '0;
      valid_reg <= 1'b0;
      head_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      count_reg <= count_next;
      valid_reg <= valid_next;
      head_reg <= head_next;
    end
  end
  // storage has no reset, only valid words are read
  always_ff @(posedge clock_in) begin
    if (push) begin
      mem_reg[wr_reg] <= fill_data_in;
    end
  end
  assign fill_ready_out = (count_reg != (AW+1)'(DEPTH));
  // drain side straight from flops, same timing as the count
  assign drain_valid_out = valid_reg;
  assign drain_data_out = head_reg;
endmodule

// File: rtl/sar_adc_parallel_control.sv
// Purpose: conversion sequencer and three-state result port
// Assumes: comparator decision arrives as a level on compare_in
// Notes: no reset pin in the part; reset_in only sets idle state
`timescale 1ns/1ns
`include "sar_ctl_defines.svh"
//
// Contract
// - depth select low sleep, high nap
// - power down low enters chosen mode
// - drive result only with read and select
// - conversion starts on convert start fall
// - strobes ignored unless select low
// - busy low through whole conversion
// - result valid by busy rising edge
// - bit register cleared at conversion start
// - no restart once a conversion began
// - bits decided msb first to lsb
// - finished word copied into output latches
// - result is positive minus negative input
// - conversion timed by own internal clock
// - two's complement, lsb is span/4096
module sar_adc_parallel_control (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // host pins, asynchronous to clock_in
  input wire sar_ctl_pkg::host_pins_type host_pins_in,
  // comparator: high when (pos - neg) is at or above dac trial
  input wire logic compare_in,
  // result fifo drain
  input wire logic stream_ready_in,
  output logic [`RESULT_WIDTH-1:0] stream_data_out,
  output logic stream_valid_out,
  // pins out
  output logic busy_n_out,
  output logic [`RESULT_WIDTH-1:0] result_bus_out,
  output logic result_bus_oe_out,
  output logic [`RESULT_WIDTH-1:0] dac_trial_out,
  output logic [1:0] power_mode_out
);
  typedef enum logic [1:0] {idle_st, convert_st, load_st} state_type;
  localparam int PW = $bits(sar_ctl_pkg::host_pins_type);
  localparam int CW = $clog2(`BIT_CYCLES + 1);

  // ==========================================
  // pin synchroniser, three stages
  logic [PW-1:0] sync1_reg, sync2_reg, sync3_reg, stable_reg, stable_next;
  sar_ctl_pkg::host_pins_type pins, pins_prev;
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sync1_reg <= {PW{1'b1}};
      sync2_reg <= {PW{1'b1}};
      sync3_reg <= {PW{1'b1}};
      stable_reg <= {PW{1'b1}};
    end else begin
      sync1_reg <= host_pins_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      stable_reg <= stable_next;
    end
  end
  // a bit follows stage two where two and three agree, else holds;
  // each bit on its own, so one pin in motion never stalls the rest
  always_comb begin
    stable_next = (sync2_reg & ~(sync2_reg ^ sync3_reg)) |
      (stable_reg & (sync2_reg ^ sync3_reg));
  end
  assign pins = sar_ctl_pkg::host_pins_type'(stable_next);
  assign pins_prev = sar_ctl_pkg::host_pins_type'(stable_reg);

  // strobe qualification
  logic start_fall, read_on;
  always_comb begin
    start_fall = !pins.chip_select_n && pins_prev.convert_start_n &&
      !pins.convert_start_n;
    read_on = !pins.chip_select_n && !pins.read_n;
  end

  // ==========================================
  // power mode
  sar_ctl_pkg::power_mode_type mode_reg, mode_next;
  always_comb begin
    if (pins.power_down_n) begin
      mode_next = sar_ctl_pkg::pwr_active_type_val;
    end else if (pins.shutdown_depth_select) begin
      mode_next = sar_ctl_pkg::pwr_nap;
    end else begin
      mode_next = sar_ctl_pkg::pwr_sleep;
    end
  end
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      mode_reg <= sar_ctl_pkg::pwr_active_type_val;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ==========================================
  // successive approximation sequencer
  state_type state_reg, state_next;
  logic [`RESULT_WIDTH-1:0] sar_reg, sar_next, latch_reg, latch_next;
  logic [3:0] bit_reg, bit_next;
  logic [CW-1:0] tick_reg, tick_next;
  logic busy_n_reg, busy_n_next, push_reg, push_next;
  logic fill_ready;

  // trial word: decided bits plus current trial bit
  function automatic logic [`RESULT_WIDTH-1:0] trial(
    input logic [`RESULT_WIDTH-1:0] sar, input logic [3:0] idx);
    trial = sar | (`RESULT_WIDTH'(1) << idx);
  endfunction

  always_comb begin
    state_next = state_reg;
    sar_next = sar_reg;
    latch_next = latch_reg;
    bit_next = bit_reg;
    tick_next = tick_reg;
    busy_n_next = busy_n_reg;
    push_next = 1'b0;
    case (state_reg)
      idle_st: begin
        // converter in nap or sleep does not start
        if (start_fall && mode_reg == sar_ctl_pkg::pwr_active_type_val) begin
          state_next = convert_st;
          sar_next = `SAR_CLEAR;
          bit_next = 4'(`RESULT_WIDTH - 1);
          tick_next = '0;
          busy_n_next = 1'b0;
        end
      end
      convert_st: begin
        if (tick_reg == CW'(`BIT_CYCLES - 1)) begin
          tick_next = '0;
          sar_next = compare_in ? trial(sar_reg, bit_reg) : sar_reg;
          if (bit_reg == 4'h0) begin
            state_next = load_st;
          end else begin
            bit_next = bit_reg - 4'h1;
          end
        end else begin
          tick_next = CW'(tick_reg + 1'b1);
        end
      end
      load_st: begin
        latch_next = {~sar_reg[`RESULT_WIDTH-1], sar_reg[`RESULT_WIDTH-2:0]};
        push_next = 1'b1;
        state_next = idle_st;
        busy_n_next = 1'b1;
      end
      default: state_next = idle_st;
    endcase
  end
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_reg <= idle_st;
      sar_reg <= `SAR_CLEAR;
      latch_reg <= `SAR_CLEAR;
      bit_reg <= 4'h0;
      tick_reg <= '0;
      busy_n_reg <= 1'b1;
      push_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sar_reg <= sar_next;
      latch_reg <= latch_next;
      bit_reg <= bit_next;
      tick_reg <= tick_next;
      busy_n_reg <= busy_n_next;
      push_reg <= push_next;
    end
  end

  // ==========================================
  // three-state result port
  logic [`RESULT_WIDTH-1:0] bus_reg, bus_next, dac_reg, dac_next;
  logic oe_reg, oe_next;
  always_comb begin
    oe_next = read_on;
    bus_next = read_on ? latch_next : `SAR_CLEAR;
    dac_next = (state_next == convert_st) ? trial(sar_next, bit_next) : `SAR_CLEAR;
  end
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      oe_reg <= 1'b0;
      bus_reg <= `SAR_CLEAR;
      dac_reg <= `SAR_CLEAR;
    end else begin
      oe_reg <= oe_next;
      bus_reg <= bus_next;
      dac_reg <= dac_next;
    end
  end

  // result stream; a full buffer drops the newest word
  result_fifo #(.WIDTH(`RESULT_WIDTH), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .fill_data_in(latch_reg),
    .fill_valid_in(push_reg),
    .fill_ready_out(fill_ready),
    .drain_data_out(stream_data_out),
    .drain_valid_out(stream_valid_out),
    .drain_ready_in(stream_ready_in)
  );

  assign busy_n_out = busy_n_reg;
  assign result_bus_out = bus_reg;
  assign result_bus_oe_out = oe_reg;
  assign dac_trial_out = dac_reg;
  assign power_mode_out = mode_reg;

  // ==========================================
  // assertions
  property p_oe_needs_read;
    @(posedge clock_in) disable iff (reset_in)
    result_bus_oe_out |-> $past(read_on);
  endproperty
  a_oe_needs_read: assert property (p_oe_needs_read) else $error("bus driven without read");
  property p_busy_on_start;
    @(posedge clock_in) disable iff (reset_in)
    (state_reg == idle_st && start_fall && mode_reg == sar_ctl_pkg::pwr_active_type_val)
      |=> !busy_n_out;
  endproperty
  a_busy_on_start: assert property (p_busy_on_start) else $error("start did not lower busy");
  property p_busy_low_in_conv;
    @(posedge clock_in) disable iff (reset_in)
    (state_reg == convert_st) |-> !busy_n_reg;
  endproperty
  a_busy_low_in_conv: assert property (p_busy_low_in_conv) else $error("busy high mid conversion");
  property p_data_at_busy_rise;
    @(posedge clock_in) disable iff (reset_in)
    $rose(busy_n_out) |-> push_reg && latch_reg == {~$past(sar_reg[11]), $past(sar_reg[10:0])};
  endproperty
  a_data_at_busy_rise: assert property (p_data_at_busy_rise) else $error("data not ready");
  property p_clear_at_start;
    @(posedge clock_in) disable iff (reset_in)
    $fell(busy_n_out) |-> sar_reg == `SAR_CLEAR && bit_reg == 4'hB;
  endproperty
  a_clear_at_start: assert property (p_clear_at_start) else $error("register not cleared");
  property p_no_restart;
    @(posedge clock_in) disable iff (reset_in)
    (state_reg == convert_st && bit_reg != 4'hB) |=> bit_reg != 4'hB;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("conversion restarted");
  property p_bit_order;
    @(posedge clock_in) disable iff (reset_in)
    (state_reg == convert_st && $past(state_reg) == convert_st && $changed(bit_reg))
      |-> bit_reg == $past(bit_reg) - 4'h1;
  endproperty
  a_bit_order: assert property (p_bit_order) else $error("bit order broken");
  property p_power_mode;
    @(posedge clock_in) disable iff (reset_in)
    (!pins.power_down_n) |=> power_mode_out != sar_ctl_pkg::pwr_active_type_val;
  endproperty
  a_power_mode: assert property (p_power_mode) else $error("shutdown not entered");
  property p_depth_choice;
    @(posedge clock_in) disable iff (reset_in)
    (!pins.power_down_n) |=> power_mode_out == ($past(pins.shutdown_depth_select) ?
      sar_ctl_pkg::pwr_nap : sar_ctl_pkg::pwr_sleep);
  endproperty
  a_depth_choice: assert property (p_depth_choice) else $error("wrong shutdown depth");
  property p_busy_idle;
    @(posedge clock_in) disable iff (reset_in)
    (state_reg == idle_st) |-> busy_n_out;
  endproperty
  a_busy_idle: assert property (p_busy_idle) else $error("busy low while idle");
  property p_select_gates;
    @(posedge clock_in) disable iff (reset_in)
    (pins.chip_select_n && state_reg == idle_st) |=> busy_n_out && !result_bus_oe_out;
  endproperty
  a_select_gates: assert property (p_select_gates) else $error("strobe taken unselected");
  property p_bit_pace;
    @(posedge clock_in) disable iff (reset_in)
    (state_reg == convert_st) |-> tick_reg < CW'(`BIT_CYCLES);
  endproperty
  a_bit_pace: assert property (p_bit_pace) else $error("bit period overrun");
  property p_load_push;
    @(posedge clock_in) disable iff (reset_in)
    (state_reg == load_st) |=> push_reg && state_reg == idle_st;
  endproperty
  a_load_push: assert property (p_load_push) else $error("finished word not passed on");
  c_conversion: cover property (@(posedge clock_in) disable iff (reset_in) $rose(busy_n_out));
  c_read: cover property (@(posedge clock_in) disable iff (reset_in) $rose(result_bus_oe_out));
  c_nap: cover property (@(posedge clock_in) disable iff (reset_in)
    power_mode_out == sar_ctl_pkg::pwr_nap);
  c_drop: cover property (@(posedge clock_in) disable iff (reset_in)
    push_reg && !fill_ready);
endmodule

// File: dv/host_model.sv
// Purpose: host pins and analog front end beside the converter
// Assumes: pins change at falling edges only
// Notes: comparator keeps a trial bit while target >= trial
`timescale 1ns/1ns
module host_model (
  // clock
  input wire logic clock_in,
  // from the device
  input wire logic busy_n_in,
  input wire logic result_bus_oe_in,
  input wire logic [11:0] result_bus_in,
  input wire logic [11:0] dac_trial_in,
  // to the device
  output sar_ctl_pkg::host_pins_type pins_out,
  output logic compare_out
);
  logic [11:0] target_reg;
  // ==========================================================
  // analog side
  // offset target of pos minus neg
  assign compare_out = (target_reg >= dac_trial_in);
  initial begin
    pins_out = 5'h1F;
    target_reg = 12'h000;
  end
  // low 80 ns, well inside 650 ns
  task automatic pulse();
    pins_out.convert_start_n = 1'b0;
    repeat (20) @(negedge clock_in);
    pins_out.convert_start_n = 1'b1;
  endtask
  task automatic start(input logic [11:0] v, input logic cs_n);
    @(negedge clock_in);
    target_reg = v ^ 12'h800;
    pins_out.chip_select_n = cs_n;
    repeat (3) @(negedge clock_in);
    pulse();
  endtask
  // busy low length and first trial word
  task automatic wait_done(output int n, output logic [11:0] t);
    int w;
    n = 0;
    for (w = 0; w < 20 && busy_n_in !== 1'b0; w++) @(negedge clock_in);
    t = dac_trial_in;
    while (busy_n_in === 1'b0 && n < 2000) begin
      @(negedge clock_in);
      n++;
    end
    // 160 ns acquisition before any next start
    repeat (40) @(negedge clock_in);
    pins_out.chip_select_n = 1'b1;
  endtask
  // read strobe; drive state during and after
  task automatic read(input logic cs_n, output logic on, output logic off,
                      output logic [11:0] d);
    @(negedge clock_in);
    pins_out.chip_select_n = cs_n;
    pins_out.read_n = 1'b0;
    repeat (8) @(negedge clock_in);
    on = result_bus_oe_in;
    d = result_bus_in;
    pins_out.read_n = 1'b1;
    repeat (8) @(negedge clock_in);
    off = result_bus_oe_in;
    pins_out.chip_select_n = 1'b1;
  endtask
  // depth select set up before power down
  task automatic power(input logic pd_n, input logic sel);
    pins_out.shutdown_depth_select = sel;
    repeat (3) @(negedge clock_in);
    pins_out.power_down_n = pd_n;
    repeat (8) @(negedge clock_in);
  endtask
endmodule

// File: dv/tb.sv
// Purpose: self-checking bench for the converter control
// Assumes: fifo drops the newest word when full
// Notes: stream words checked from a queue of expected words
`timescale 1ns/1ns
`include "sar_ctl_defines.svh"
module tb;
  logic clock_in, reset_in, stream_ready_in, drain_on;
  logic stream_valid_out, busy_n_out, result_bus_oe_out, compare_in, on, off;
  logic [11:0] stream_data_out, result_bus_out, dac_trial_out, v, d, t;
  logic [1:0] power_mode_out;
  sar_ctl_pkg::host_pins_type host_pins_in;
  logic [11:0] q[$];
  int errors, cmp_count, n;
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  sar_adc_parallel_control i_sar_adc_parallel_control (
    .clock_in(clock_in), .reset_in(reset_in), .host_pins_in(host_pins_in),
    .compare_in(compare_in), .stream_ready_in(stream_ready_in),
    .stream_data_out(stream_data_out), .stream_valid_out(stream_valid_out),
    .busy_n_out(busy_n_out), .result_bus_out(result_bus_out),
    .result_bus_oe_out(result_bus_oe_out), .dac_trial_out(dac_trial_out),
    .power_mode_out(power_mode_out));
  host_model i_host_model (
    .clock_in(clock_in), .busy_n_in(busy_n_out),
    .result_bus_oe_in(result_bus_oe_out), .result_bus_in(result_bus_out),
    .dac_trial_in(dac_trial_out), .pins_out(host_pins_in),
    .compare_out(compare_in));
  // ==========================================================
  // compare and verdict
  task automatic check(input string what, input logic [11:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // drain side: draw ready first, then check the word the next edge takes
  always @(negedge clock_in) begin
    stream_ready_in = drain_on ? 1'($urandom) : 1'b0;
    if (!reset_in && stream_valid_out === 1'b1 && stream_ready_in === 1'b1) begin
      if (q.size() == 0) check("stream extra word", 12'h001, 12'h000);
      else check("stream word", stream_data_out, q.pop_front());
    end
  end
  // watchdog, about two and a half times the expected run
  initial begin
    #(10000 * `CLK_PERIOD_NS);
    errors++;
    finish_test();
  end
  // ==========================================================
  // main sequence
  initial begin
    errors = 0;
    cmp_count = 0;
    reset_in = 1'b1;
    drain_on = 1'b0;
    void'($urandom(35));
    repeat (10) @(negedge clock_in);
    reset_in = 1'b0;
    repeat (2) @(negedge clock_in);
    check("busy idle", {11'h000, busy_n_out}, 12'h001);
    check("mode active", {10'h000, power_mode_out}, 12'h000);
    i_host_model.power(1'b0, 1'b0);
    check("mode sleep", {10'h000, power_mode_out}, {10'h000, sar_ctl_pkg::pwr_sleep});
    i_host_model.power(1'b0, 1'b1);
    check("mode nap", {10'h000, power_mode_out}, {10'h000, sar_ctl_pkg::pwr_nap});
    fork
      i_host_model.start(12'h123, 1'b0);
      i_host_model.wait_done(n, t);
    join
    check("start in shutdown", 12'(n), 12'h000);
    i_host_model.power(1'b1, 1'b1);
    check("mode woken", {10'h000, power_mode_out}, 12'h000);
    fork
      i_host_model.start(12'h456, 1'b1);
      i_host_model.wait_done(n, t);
    join
    check("start unselected", 12'(n), 12'h000);
    // boundary codes first, then random; fifo stalls throughout
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 12'h800 : (i == 1) ? 12'h7FF : (i == 2) ? 12'h000 : 12'($urandom);
      fork
        i_host_model.start(v, 1'b0);
        i_host_model.wait_done(n, t);
        if (i == 3) begin
          repeat (100) @(negedge clock_in);
          i_host_model.pulse();
        end
      join
      check("busy low length", 12'(n), 12'(12 * `BIT_CYCLES + 1));
      check("first trial", t, 12'h800);
      if (q.size() < `FIFO_DEPTH) q.push_back(v);
      i_host_model.read(1'b0, on, off, d);
      check("bus driven", {11'h000, on}, 12'h001);
      check("bus word", d, v);
      check("bus released", {11'h000, off}, 12'h000);
    end
    i_host_model.read(1'b1, on, off, d);
    check("read unselected", {11'h000, on}, 12'h000);
    drain_on = 1'b1;
    for (int w = 0; w < 400 && q.size() > 0; w++) @(negedge clock_in);
    repeat (4) @(negedge clock_in);
    check("words left", 12'(q.size()), 12'h000);
    check("stream empty", {11'h000, stream_valid_out}, 12'h000);
    finish_test();
  end
endmodule
